/* core/ccg_pkg.sv */
// shared constants for the clock output gating and loss-of-signal block
package ccg_pkg;

  // clock and loss timing
  localparam int CLK_PERIOD_NS   = 50;
  localparam int LOS_TIMEOUT_NS  = 1000;
  localparam int LOS_CYC_INT     = (LOS_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W           = 8;
  localparam logic [CNT_W-1:0] LOS_TIMEOUT_CYC = CNT_W'(LOS_CYC_INT);

  // register byte offsets
  localparam logic [31:0] OFF_OUT_EN    = 32'h0000_0000;
  localparam logic [31:0] OFF_IN_CFG    = 32'h0000_0004;
  localparam logic [31:0] OFF_IN_SEL    = 32'h0000_0008;
  localparam logic [31:0] OFF_LOSS_STAT = 32'h0000_000c;
  localparam logic [31:0] OFF_INT_STAT  = 32'h0000_0010;
  localparam logic [31:0] OFF_INT_MASK  = 32'h0000_0014;

  // loss status fields
  localparam int LS_EVT_BIT   = 0;
  localparam int LS_LIVE_BIT  = 1;
  localparam int LS_PARK_BIT  = 2;
  localparam int LS_ARMED_BIT = 3;

  // input config fields: bias at 2*i, termination at 2*i+1
  localparam int CFG_BIAS_OFS = 0;
  localparam int CFG_TERM_OFS = 1;

  // interrupt fields
  localparam int INT_W        = 2;
  localparam int INT_LOSS_BIT = 0;
  localparam int INT_REST_BIT = 1;

  // reset values
  localparam logic             SEL_RST      = 1'b0;
  localparam logic [INT_W-1:0] INT_MASK_RST = 2'h0;

  // bus encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD    = 3'h2;
  localparam logic       HRESP_OKAY    = 1'b0;

  typedef enum logic [1:0] {
    CCG_WAIT_EDGE,
    CCG_PRESENT,
    CCG_LOST
  } ccg_los_state_t;

endpackage

/* core/ccg_out_gate.sv */
// glitch-free gate for one output clock
`timescale 1ns/1ns
`default_nettype none

module ccg_out_gate (
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  input  wire logic ref_path,
  input  wire logic enable_req,
  output var  logic clock_out,
  output var  logic gate_open
);

  logic prev_reg;
  logic gate_reg;
  logic out_reg;
  wire  fall_edge;

  // gate moves only at a high-to-low step of the running path
  assign fall_edge = prev_reg & ~ref_path;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      prev_reg <= 1'b0;
      gate_reg <= 1'b0;
      out_reg  <= 1'b0;
    end else begin
      prev_reg <= ref_path;
      if (fall_edge) begin
        gate_reg <= enable_req;
      end
      out_reg <= ref_path & gate_reg;
    end
  end

  assign clock_out = out_reg;
  assign gate_open = gate_reg;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  AST_GATE_ONLY_AT_FALL: assert property ($changed(gate_reg) |-> $past(fall_edge))
    else $error("gate changed outside a falling step");
  AST_STATIC_REF_HOLDS: assert property ((!fall_edge) [*2] |-> $stable(gate_reg))
    else $error("gate changed while reference static");
  AST_DISABLE_TAKES: assert property ((fall_edge && !enable_req) |=> !gate_reg ##1 !out_reg)
    else $error("disable request not applied at falling step");
  AST_NO_RUNT: assert property ($rose(out_reg) |-> $past(ref_path) && $past(gate_reg))
    else $error("output rose without open gate");

endmodule // ccg_out_gate

`default_nettype wire

/* core/ccg_clock_gating.sv */
// loss-of-signal detection, input parking and output gating with AHB-Lite registers
//
// Added by the designer: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ns
`default_nettype none

module ccg_clock_gating #(
  parameter int NUM_INPUTS  = 2,
  parameter int NUM_OUTPUTS = 8
) (
  input  wire logic                   sys_clk,
  input  wire logic                   sys_rst,
  // ahb-lite slave
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [31:0]            hwdata,
  input  wire logic                   hready,
  output var  logic                   hreadyout,
  output var  logic                   hresp,
  output var  logic [31:0]            hrdata,
  // reference inputs and enables
  input  wire logic [NUM_INPUTS-1:0]  reference_clock_in,
  input  wire logic [NUM_OUTPUTS-1:0] out_en_pin_n,
  input  wire logic [NUM_OUTPUTS-1:0] sideband_disable,
  // outputs
  output var  logic [NUM_OUTPUTS-1:0] clock_out,
  output var  logic [NUM_INPUTS-1:0]  ac_coupled_bias_en,
  output var  logic [NUM_INPUTS-1:0]  input_term_en,
  output var  logic                   loss_indicator_n_o,
  output var  logic                   loss_indicator_n_oe,
  output var  logic                   irq
);

  localparam int  CFG_W  = 2 * NUM_INPUTS;
  localparam logic MUX_EN = (NUM_INPUTS > 1);
  localparam ccg_pkg::ccg_los_state_t LOS_RST_STATE =
    (NUM_INPUTS > 1) ? ccg_pkg::CCG_PRESENT : ccg_pkg::CCG_WAIT_EDGE;

  function automatic logic [31:0] zext_out(input logic [NUM_OUTPUTS-1:0] v);
    zext_out = 32'(v);
  endfunction

  // bus state
  logic [31:0]             addr_reg;
  logic                    wr_pend_reg;
  logic                    rd_pend_reg;
  logic [31:0]             hrdata_reg;
  // software registers
  logic [NUM_OUTPUTS-1:0]  out_en_reg;
  logic [CFG_W-1:0]        in_cfg_reg;
  logic                    sel_reg;
  logic                    evt_reg;
  logic [ccg_pkg::INT_W-1:0] int_stat_reg;
  logic [ccg_pkg::INT_W-1:0] int_mask_reg;
  // detector
  ccg_pkg::ccg_los_state_t state_reg;
  ccg_pkg::ccg_los_state_t state_next;
  logic [ccg_pkg::CNT_W-1:0] cnt_reg;
  logic [ccg_pkg::CNT_W-1:0] cnt_next;
  logic                    ref_q_reg;
  logic                    sel_q_reg;
  logic                    evt_next;
  logic [ccg_pkg::INT_W-1:0] int_stat_next;

  // address phase and access decode
  wire        take_phase = hsel & hready & (htrans == ccg_pkg::HTRANS_NONSEQ);
  wire        take_wr    = take_phase & hwrite & (hsize == ccg_pkg::HSIZE_WORD);
  wire        take_rd    = take_phase & ~hwrite;
  wire        wr_fire    = wr_pend_reg;
  wire        hit_out_en = (addr_reg == ccg_pkg::OFF_OUT_EN);
  wire        hit_in_cfg = (addr_reg == ccg_pkg::OFF_IN_CFG);
  wire        hit_in_sel = (addr_reg == ccg_pkg::OFF_IN_SEL);
  wire        hit_loss   = (addr_reg == ccg_pkg::OFF_LOSS_STAT);
  wire        hit_istat  = (addr_reg == ccg_pkg::OFF_INT_STAT);
  wire        hit_imask  = (addr_reg == ccg_pkg::OFF_INT_MASK);
  wire        evt_w1c    = wr_fire & hit_loss & hwdata[ccg_pkg::LS_EVT_BIT];
  wire        istat_rd   = rd_pend_reg & hit_istat;

  // detector decode
  wire        sel_eff    = MUX_EN & sel_reg;
  wire        ref_sel    = reference_clock_in[sel_eff];
  wire        ref_edge   = ref_sel ^ ref_q_reg;
  wire        sel_moved  = sel_eff ^ sel_q_reg;
  wire        armed      = (state_reg != ccg_pkg::CCG_WAIT_EDGE);
  wire        loss_now   = (state_reg == ccg_pkg::CCG_LOST);
  wire        timed_out  = (cnt_reg == ccg_pkg::LOS_TIMEOUT_CYC);
  wire        loss_rise  = (state_reg == ccg_pkg::CCG_PRESENT) & (state_next == ccg_pkg::CCG_LOST);
  wire        restore    = (state_reg == ccg_pkg::CCG_LOST) & (state_next == ccg_pkg::CCG_PRESENT);
  wire        ref_path   = ref_q_reg & (state_reg == ccg_pkg::CCG_PRESENT);
  // path is forced low whenever the detector is not in the running state
  wire        parked     = (state_reg != ccg_pkg::CCG_PRESENT);

  // combined enables
  wire [NUM_OUTPUTS-1:0] en_req = out_en_reg & ~out_en_pin_n & ~sideband_disable;
  wire [NUM_OUTPUTS-1:0] gate_open;

  wire [3:0]  loss_fields = {armed, parked, ~loss_now, evt_reg};
  wire [31:0] rd_val =
    hit_out_en ? zext_out(out_en_reg) :
    hit_in_cfg ? 32'(in_cfg_reg) :
    hit_in_sel ? 32'(sel_reg) :
    hit_loss   ? 32'(loss_fields) :
    hit_istat  ? 32'(int_stat_reg) :
    hit_imask  ? 32'(int_mask_reg) : 32'h0000_0000;

  // loss detector state machine
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ccg_pkg::CCG_WAIT_EDGE: begin
        if (ref_edge) begin
          state_next = ccg_pkg::CCG_PRESENT;
        end
      end
      ccg_pkg::CCG_PRESENT: begin
        if (timed_out && !ref_edge) begin
          state_next = ccg_pkg::CCG_LOST;
        end
      end
      ccg_pkg::CCG_LOST: begin
        if (ref_edge && !sel_moved) begin
          state_next = ccg_pkg::CCG_PRESENT;
        end
      end
      default: begin
        state_next = LOS_RST_STATE;
      end
    endcase
  end

  // saturating count of cycles since the last edge
  assign cnt_next = (ref_edge || sel_moved || !armed) ? '0 :
                    timed_out ? cnt_reg : cnt_reg + 1'b1;

  // set wins over clear
  assign evt_next      = loss_rise | (evt_reg & ~evt_w1c);
  assign int_stat_next = {restore, loss_rise} | (int_stat_reg & ~{ccg_pkg::INT_W{istat_rd}});

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_reg <= LOS_RST_STATE;
      cnt_reg   <= '0;
      ref_q_reg <= 1'b0;
      sel_q_reg <= 1'b0;
      evt_reg   <= 1'b0;
      int_stat_reg <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      ref_q_reg <= ref_sel;
      sel_q_reg <= sel_eff;
      evt_reg   <= evt_next;
      int_stat_reg <= int_stat_next;
    end
  end

  // bus slave: writes zero wait, reads one wait state
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      addr_reg    <= 32'h0000_0000;
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      hrdata_reg  <= 32'h0000_0000;
    end else begin
      wr_pend_reg <= take_wr;
      rd_pend_reg <= take_rd;
      if (take_phase) begin
        addr_reg <= haddr;
      end
      if (rd_pend_reg) begin
        hrdata_reg <= rd_val;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      out_en_reg   <= {NUM_OUTPUTS{1'b1}};
      in_cfg_reg   <= '0;
      sel_reg      <= ccg_pkg::SEL_RST;
      int_mask_reg <= ccg_pkg::INT_MASK_RST;
    end else if (wr_fire) begin
      if (hit_out_en) begin
        out_en_reg <= hwdata[NUM_OUTPUTS-1:0];
      end
      if (hit_in_cfg) begin
        in_cfg_reg <= hwdata[CFG_W-1:0];
      end
      if (hit_in_sel) begin
        sel_reg <= hwdata[0];
      end
      if (hit_imask) begin
        int_mask_reg <= hwdata[ccg_pkg::INT_W-1:0];
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_INPUTS; gi = gi + 1) begin : g_in
      assign ac_coupled_bias_en[gi] = in_cfg_reg[2*gi + ccg_pkg::CFG_BIAS_OFS];
      assign input_term_en[gi]      = in_cfg_reg[2*gi + ccg_pkg::CFG_TERM_OFS];
    end
    for (gi = 0; gi < NUM_OUTPUTS; gi = gi + 1) begin : g_out
      ccg_out_gate u_gate (
        .sys_clk    (sys_clk),
        .sys_rst    (sys_rst),
        .ref_path   (ref_path),
        .enable_req (en_req[gi]),
        .clock_out  (clock_out[gi]),
        .gate_open  (gate_open[gi])
      );
    end
  endgenerate

  assign hreadyout           = ~rd_pend_reg;
  assign hresp               = ccg_pkg::HRESP_OKAY;
  assign hrdata              = hrdata_reg;
  assign loss_indicator_n_o  = 1'b0;
  assign loss_indicator_n_oe = armed & loss_now;
  assign irq                 = |(int_stat_reg & int_mask_reg);

  // assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  sequence s_write_cfg;
    take_wr && (haddr == ccg_pkg::OFF_IN_CFG);
  endsequence

  sequence s_static_timeout;
    (state_reg == ccg_pkg::CCG_PRESENT) && timed_out && !ref_edge;
  endsequence

  // register write and read sequences
  sequence s_write_out_en;
    take_wr && (haddr == ccg_pkg::OFF_OUT_EN);
  endsequence

  sequence s_loss_read;
    rd_pend_reg && hit_loss;
  endsequence

  AST_LOSS_ON_TIMEOUT: assert property (s_static_timeout |=> loss_now && loss_indicator_n_oe && evt_reg)
    else $error("loss not flagged after timeout");
  AST_RELEASED_UNTIL_EDGE: assert property (!armed |-> !loss_indicator_n_oe)
    else $error("indicator driven before first edge");
  AST_ARM_ON_EDGE: assert property ($rose(armed) |-> $past(ref_edge))
    else $error("armed without reference edge");
  AST_UNSELECTED_IGNORED: assert property ((armed && !ref_edge && !sel_moved && !timed_out)
                                           |=> cnt_reg == $past(cnt_reg) + 1'b1)
    else $error("count reset without selected edge");
  AST_PARKED_LOW: assert property (loss_now [*2] |-> !ref_path && !(|clock_out))
    else $error("input path not parked after loss");
  AST_OUT_EN_RESET: assert property ($past(sys_rst) |-> out_en_reg == {NUM_OUTPUTS{1'b1}})
    else $error("output enable reset value wrong");
  AST_CFG_WRITE: assert property (s_write_cfg ##1 1'b1 |=>
                                  {input_term_en[0], ac_coupled_bias_en[0]} == $past(hwdata[1:0]))
    else $error("input config bits not applied");
  AST_EVT_STICKY: assert property ((evt_reg && !evt_w1c) |=> evt_reg)
    else $error("event flag lost without clear");
  AST_EVT_CLEAR: assert property ((evt_reg && evt_w1c && !loss_rise) |=> !evt_reg)
    else $error("event flag not cleared by write of one");
  AST_READ_ANSWER: assert property (take_rd |=> !hreadyout ##1 hreadyout)
    else $error("read answer timing wrong");
  AST_OUT_EN_WRITE: assert property (s_write_out_en ##1 1'b1 |=>
                                     out_en_reg == $past(hwdata[NUM_OUTPUTS-1:0]))
    else $error("output enable bits not applied");
  AST_CFG_WRITE_ALL: assert property (s_write_cfg ##1 1'b1 |=>
                                      in_cfg_reg == $past(hwdata[CFG_W-1:0]))
    else $error("per-input config bits not applied");
  AST_LIVE_READBACK: assert property (s_loss_read |=> hrdata[ccg_pkg::LS_LIVE_BIT] == !$past(loss_now)
                                      && hrdata[ccg_pkg::LS_PARK_BIT] == $past(parked))
    else $error("loss readback fields wrong");

  // detector and output gate properties
  AST_EVT_SET_WINS: assert property (loss_rise |=> evt_reg && int_stat_reg[ccg_pkg::INT_LOSS_BIT])
    else $error("loss event not recorded");
  AST_RESTORE_ON_EDGE: assert property ((loss_now && ref_edge && !sel_moved) |=>
                                        !loss_now && int_stat_reg[ccg_pkg::INT_REST_BIT])
    else $error("detector did not recover on edge");
  AST_SEL_RESTARTS: assert property (sel_moved |=> cnt_reg == '0)
    else $error("count not restarted on input change");
  AST_WAIT_NO_COUNT: assert property (!armed |=> cnt_reg == '0 && !loss_now)
    else $error("detector ran before first edge");
  AST_OUT_NEEDS_GATE: assert property (!(|(clock_out & ~gate_open)))
    else $error("output running with gate closed");

endmodule // ccg_clock_gating

`default_nettype wire

/* testbench/ccg_ref_src.sv */
// reference clock source model for one input
`timescale 1ns/1ns
`default_nettype none

module ccg_ref_src #(
  parameter int HALF = 2
) (
  input  wire logic sys_clk,
  input  wire logic run,
  output var  logic ref_o
);
  int cnt = 0;
  initial ref_o = 1'b0;
  // finishes a high phase before standing still low
  always @(posedge sys_clk) begin
    if (run || ref_o) begin
      if (cnt == HALF - 1) begin
        cnt   <= 0;
        ref_o <= ~ref_o;
      end else begin
        cnt <= cnt + 1;
      end
    end
  end
endmodule // ccg_ref_src

`default_nettype wire

/* testbench/clock_output_gating_los_tb_top.sv */
// self-checking bench for clock gating and loss detection
`timescale 1ns/1ns
`default_nettype none

module clock_output_gating_los_tb_top;
  logic        sys_clk, sys_rst, hsel, hwrite, hreadyout, hresp, irq, oe_n_o, oe;
  logic [31:0] haddr, hwdata, hrdata, r, en, pn, sb, c, seed;
  logic [1:0]  htrans, run, refc, bias, term;
  logic [2:0]  hsize;
  logic [7:0]  pin_n, sbd, clk_o, seen;
  logic [31:0] mreg [logic [31:0]];
  int          miscompares, samples_checked, hrun [8];
  logic        run_s, ref_s, oe_s;

  ccg_clock_gating dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .reference_clock_in(refc),
    .out_en_pin_n(pin_n), .sideband_disable(sbd), .clock_out(clk_o), .ac_coupled_bias_en(bias),
    .input_term_en(term), .loss_indicator_n_o(oe_n_o), .loss_indicator_n_oe(oe), .irq(irq));
  ccg_ref_src src0 (.sys_clk(sys_clk), .run(run[0]), .ref_o(refc[0]));
  ccg_ref_src src1 (.sys_clk(sys_clk), .run(run[1]), .ref_o(refc[1]));
  // single-input variant shares the bus and watches its own reference
  ccg_clock_gating #(.NUM_INPUTS(1)) dut_single (.sys_clk(sys_clk), .sys_rst(sys_rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(), .hresp(), .hrdata(), .reference_clock_in(ref_s), .out_en_pin_n(pin_n),
    .sideband_disable(sbd), .clock_out(), .ac_coupled_bias_en(), .input_term_en(),
    .loss_indicator_n_o(), .loss_indicator_n_oe(oe_s), .irq());
  ccg_ref_src src_s (.sys_clk(sys_clk), .run(run_s), .ref_o(ref_s));

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, exp, got);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    haddr  <= a;
    hwrite <= w;
    htrans <= ccg_pkg::HTRANS_NONSEQ;
    do @(negedge sys_clk); while (hreadyout !== 1'b1);
    @(posedge sys_clk);
    htrans <= 2'h0;
    hwdata <= d;
    do @(negedge sys_clk); while (hreadyout !== 1'b1);
    r = hrdata;
    @(posedge sys_clk);
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
    if (mreg.exists(a)) mreg[a] = d;
  endtask

  task automatic rd(input logic [31:0] a);
    bus(1'b0, a, 32'h0);
    chk("reg", r, mreg.exists(a) ? mreg[a] : 32'h0);
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // every output pulse must be a full reference high phase
  always @(negedge sys_clk) begin
    for (int i = 0; i < 8; i++) begin
      if (clk_o[i] === 1'b1) hrun[i]++;
      else begin
        if (hrun[i] != 0) chk("pulse", hrun[i], 2);
        hrun[i] = 0;
      end
    end
  end

  initial begin
    repeat (5000) @(posedge sys_clk);
    miscompares++;
    finish_test();
  end

  initial begin
    seed = 32'd49565;
    {hsel, hwrite, sys_rst, run, run_s} = {3'b101, 2'b11, 1'b0};
    {haddr, hwdata, htrans, hsize} = {64'h0, 2'h0, ccg_pkg::HSIZE_WORD};
    {pin_n, sbd} = 16'h0;
    mreg[ccg_pkg::OFF_OUT_EN] = 32'hff;
    mreg[ccg_pkg::OFF_IN_CFG] = 32'h0;
    mreg[ccg_pkg::OFF_IN_SEL] = 32'h0;
    mreg[ccg_pkg::OFF_INT_MASK] = 32'h0;
    wait_cyc(6);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    foreach (mreg[a]) rd(a);
    rd(32'h20);
    chk("bias", {bias, term}, 4'h0);
    chk("oe1", oe_s, 1'b0);
    $display("reset test done");
    for (int k = 0; k < 4; k++) begin
      c = xs() & 32'hf;
      wr(ccg_pkg::OFF_IN_CFG, c);
      rd(ccg_pkg::OFF_IN_CFG);
      chk("bias", bias, {c[2], c[0]});
      chk("term", term, {c[3], c[1]});
    end
    $display("input config test done");
    for (int k = 0; k < 4; k++) begin
      {en, pn, sb} = {xs() & 32'hff, xs(), xs()};
      if (k == 0) {en, pn, sb} = {32'hff, 64'h0};
      wr(ccg_pkg::OFF_OUT_EN, en);
      pin_n <= pn[7:0];
      sbd   <= sb[7:0];
      wait_cyc(12);
      seen = 8'h0;
      repeat (16) begin
        @(negedge sys_clk);
        seen = seen | clk_o;
      end
      chk("gate", {24'h0, seen}, en & ~pn & ~sb & 32'hff);
    end
    $display("gating test done");
    wr(ccg_pkg::OFF_INT_MASK, 32'h1);
    bus(1'b0, ccg_pkg::OFF_INT_STAT, 32'h0);
    run[0] <= 1'b0;
    wait_cyc(30);
    chk("oe", oe, 1'b1);
    chk("irq", irq, 1'b1);
    chk("outs", clk_o, 8'h0);
    bus(1'b0, ccg_pkg::OFF_LOSS_STAT, 32'h0);
    chk("stat", r & 32'h7, 32'h5);
    bus(1'b0, ccg_pkg::OFF_INT_STAT, 32'h0);
    chk("int", r, 32'h1);
    chk("irq", irq, 1'b0);
    run[0] <= 1'b1;
    wait_cyc(10);
    chk("oe", oe, 1'b0);
    chk("irq", irq, 1'b0);
    wr(ccg_pkg::OFF_LOSS_STAT, 32'h0);
    bus(1'b0, ccg_pkg::OFF_LOSS_STAT, 32'h0);
    chk("stat", r & 32'h7, 32'h3);
    wr(ccg_pkg::OFF_LOSS_STAT, 32'h1);
    bus(1'b0, ccg_pkg::OFF_LOSS_STAT, 32'h0);
    chk("stat", r & 32'h7, 32'h2);
    bus(1'b0, ccg_pkg::OFF_INT_STAT, 32'h0);
    chk("int", r, 32'h2);
    $display("loss test done");
    wr(ccg_pkg::OFF_OUT_EN, 32'h0);
    wait_cyc(8);
    chk("outs", clk_o, 8'h0);
    wr(ccg_pkg::OFF_IN_SEL, 32'h1);
    run[0] <= 1'b0;
    wait_cyc(30);
    chk("oe", oe, 1'b0);
    run[1] <= 1'b0;
    wait_cyc(30);
    chk("oe", oe, 1'b1);
    $display("select test done");
    run_s <= 1'b1;
    wait_cyc(10);
    chk("oe1", oe_s, 1'b0);
    run_s <= 1'b0;
    wait_cyc(30);
    chk("oe1", oe_s, 1'b1);
    $display("single input test done");
    finish_test();
  end
endmodule // clock_output_gating_los_tb_top

`default_nettype wire
